// ---- core/spi_cfg_pkg.sv ----
// Constants and carrier types for the SPI option and bit-rate block
package spi_cfg_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OPTION_CONTROL_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] BIT_RATE_SELECT_ADDR = 12'h004;
    localparam logic [7:0] OPTION_CONTROL_RESET = 8'h00;
    localparam logic [7:0] BIT_RATE_SELECT_RESET = 8'h00;
    localparam int FAULT_EN_BIT = 4;
    localparam int DRIVE_EN_BIT = 3;
    localparam int HALT_WAIT_BIT = 1;
    localparam int SINGLE_WIRE_BIT = 0;
    localparam int PRESCALE_LSB = 4;
    localparam int RATE_LSB = 0;
    localparam int FIELD_W = 3;
    localparam logic [15:0] RATE_BASE = 16'h0002;
    localparam logic [15:0] RATE_ONE = 16'h0001;

    typedef struct packed {
        logic faultDetectEnable;
        logic singleWireDriveEnable;
        logic haltInWait;
        logic singleWireSelect;
    } option_t;

    typedef struct packed {
        logic [FIELD_W-1:0] prescaleField;
        logic [FIELD_W-1:0] rateDivideField;
    } bit_rate_t;

    // One pad: value driven, enable low while driving
    typedef struct packed {
        logic out;
        logic oe_n;
    } pad_t;

    typedef struct packed {
        option_t opt;
        bit_rate_t rate;
        logic [FIELD_W-1:0] preCnt;
        logic [7:0] rateCnt;
        logic tick;
    } state_t;
endpackage

// ---- core/spi_pin_mode_and_baud_config.sv ----
// SPI option control, pin routing and bit-rate divider chain
//
// Summary of operation
// - Unimplemented option bits 7,6,5,2 read zero
// - Slave: ignore fault enable, select input
// - Master, fault disabled: select pin released
// - Master, fault enabled: fault input or output
// - Single-wire: drive enable gates data driver
// - Two-wire: drive enable has no effect
// - Single-wire: slave uses MISO, master MOSI
// - Two-wire: separate input and output pins
// - Halt-in-wait stops clocks in wait mode
// - Bit-rate register accessible at any time
// - Prescaler divides by field plus one
// - Rate divider divides by two^(field+1)
// - Bus clock feeds prescaler feeds divider
// - Divider output is master bit clock
// - Select output enable picks fault/driven
// - Single-wire: unused data pin released
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module spi_pin_mode_and_baud_config
    import spi_cfg_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic masterSelect,
    input wire logic selectOutputEnable,
    input wire logic waitMode,
    input wire logic shiftTxd,
    output logic shiftRxd,
    input wire logic shiftSelectLevel,
    input wire logic mosiIn,
    output pad_t mosiPad,
    input wire logic misoIn,
    output pad_t misoPad,
    input wire logic selectIn,
    output pad_t selectPad,
    output logic slaveSelect_n,
    output logic faultSense_n,
    output logic mosiGpio,
    output logic misoGpio,
    output logic selectGpio,
    output logic clocksRun,
    output logic bitRateTick
);
    state_t st_r;
    state_t st_nxt;
    logic wrEn;
    logic hitOpt;
    logic hitRate;
    logic [7:0] rateLimit;
    logic [FIELD_W-1:0] preLimit;

    assign hitOpt = (paddr == OPTION_CONTROL_ADDR);
    assign hitRate = (paddr == BIT_RATE_SELECT_ADDR);
    assign wrEn = psel && penable && pwrite;
    // Zero wait states; no register access is ever held off
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hitOpt && !hitRate;

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (hitOpt)
        begin
            prdata[FAULT_EN_BIT] = st_r.opt.faultDetectEnable;
            prdata[DRIVE_EN_BIT] = st_r.opt.singleWireDriveEnable;
            prdata[HALT_WAIT_BIT] = st_r.opt.haltInWait;
            prdata[SINGLE_WIRE_BIT] = st_r.opt.singleWireSelect;
        end
        else if (hitRate)
        begin
            prdata[PRESCALE_LSB +: FIELD_W] = st_r.rate.prescaleField;
            prdata[RATE_LSB +: FIELD_W] = st_r.rate.rateDivideField;
        end
    end

    assign preLimit = st_r.rate.prescaleField;
    assign rateLimit = 8'((RATE_BASE << st_r.rate.rateDivideField) - RATE_ONE);
    // Halted clocks freeze the chain where it stands
    assign clocksRun = !(waitMode && st_r.opt.haltInWait);

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (wrEn && hitOpt)
        begin
            st_nxt.opt.faultDetectEnable = pwdata[FAULT_EN_BIT];
            st_nxt.opt.singleWireDriveEnable = pwdata[DRIVE_EN_BIT];
            st_nxt.opt.haltInWait = pwdata[HALT_WAIT_BIT];
            st_nxt.opt.singleWireSelect = pwdata[SINGLE_WIRE_BIT];
        end
        if (wrEn && hitRate)
        begin
            // New rate restarts the chain so no stale terminal count is used
            st_nxt.rate.prescaleField = pwdata[PRESCALE_LSB +: FIELD_W];
            st_nxt.rate.rateDivideField = pwdata[RATE_LSB +: FIELD_W];
            st_nxt.preCnt = '0;
            st_nxt.rateCnt = '0;
        end
        else if (!masterSelect)
        begin
            st_nxt.preCnt = '0;
            st_nxt.rateCnt = '0;
        end
        else if (clocksRun)
        begin
            // Bus clock drives prescaler, prescaler carry drives divider
            if (st_r.preCnt == preLimit)
            begin
                st_nxt.preCnt = '0;
                if (st_r.rateCnt == rateLimit)
                begin
                    st_nxt.rateCnt = '0;
                    st_nxt.tick = 1'b1;
                end
                else
                begin
                    st_nxt.rateCnt = st_r.rateCnt + 8'h01;
                end
            end
            else
            begin
                st_nxt.preCnt = st_r.preCnt + 3'h1;
            end
        end
        if (srst)
        begin
            st_nxt = '0;
            st_nxt.opt = option_t'(OPTION_CONTROL_RESET[3:0]);
            st_nxt.rate = bit_rate_t'(BIT_RATE_SELECT_RESET[5:0]);
        end
    end

    always_ff @(posedge clock)
    begin
        st_r <= st_nxt;
    end

    assign bitRateTick = st_r.tick;

    // Data pin routing
    always_comb
    begin
        mosiPad = '{out: 1'b0, oe_n: 1'b1};
        misoPad = '{out: 1'b0, oe_n: 1'b1};
        mosiGpio = 1'b0;
        misoGpio = 1'b0;
        shiftRxd = 1'b0;
        if (!st_r.opt.singleWireSelect)
        begin
            // Drive enable is not looked at here
            if (masterSelect)
            begin
                mosiPad = '{out: shiftTxd, oe_n: 1'b0};
                shiftRxd = misoIn;
            end
            else
            begin
                misoPad = '{out: shiftTxd, oe_n: 1'b0};
                shiftRxd = mosiIn;
            end
        end
        else if (masterSelect)
        begin
            mosiPad = '{out: shiftTxd, oe_n: !st_r.opt.singleWireDriveEnable};
            shiftRxd = mosiIn;
            misoGpio = 1'b1;
        end
        else
        begin
            misoPad = '{out: shiftTxd, oe_n: !st_r.opt.singleWireDriveEnable};
            shiftRxd = misoIn;
            mosiGpio = 1'b1;
        end
    end

    // Select pin routing
    always_comb
    begin
        selectPad = '{out: 1'b1, oe_n: 1'b1};
        selectGpio = 1'b0;
        slaveSelect_n = 1'b1;
        faultSense_n = 1'b1;
        if (!masterSelect)
        begin
            slaveSelect_n = selectIn;
        end
        else if (!st_r.opt.faultDetectEnable)
        begin
            selectGpio = 1'b1;
        end
        else if (!selectOutputEnable)
        begin
            faultSense_n = selectIn;
        end
        else
        begin
            selectPad = '{out: shiftSelectLevel, oe_n: 1'b0};
        end
    end

    // Helper: chain steps since the counters were last zero
    logic [15:0] gapCnt;
    always_ff @(posedge clock)
    begin
        if (srst || !masterSelect || (wrEn && hitRate))
        begin
            gapCnt <= 16'h0000;
        end
        else if (clocksRun)
        begin
            // Halted chain holds, so the count holds too
            gapCnt <= st_nxt.tick ? 16'h0000 : gapCnt + 16'h0001;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    AST_OPT_RESERVED_ZERO: assert property (psel && hitOpt |->
        prdata[7:5] == 3'h0 && prdata[2] == 1'b0)
        else $error("reserved option bits not zero");
    AST_SLAVE_SELECT_INPUT: assert property (!masterSelect |->
        slaveSelect_n == selectIn && selectPad.oe_n && !selectGpio)
        else $error("slave select not an input");
    AST_MASTER_SELECT_RELEASED: assert property (masterSelect && !st_r.opt.faultDetectEnable |->
        selectGpio && selectPad.oe_n && faultSense_n)
        else $error("select pin not released");
    AST_FAULT_OR_DRIVE: assert property (masterSelect && st_r.opt.faultDetectEnable |->
        (selectOutputEnable ? !selectPad.oe_n : (selectPad.oe_n && faultSense_n == selectIn)))
        else $error("select pin role wrong");
    AST_SINGLE_WIRE_DRIVER: assert property (st_r.opt.singleWireSelect && masterSelect |->
        mosiPad.oe_n == !st_r.opt.singleWireDriveEnable && misoGpio && misoPad.oe_n)
        else $error("single wire master pin wrong");
    AST_TWO_WIRE_SEPARATE: assert property (!st_r.opt.singleWireSelect && masterSelect |->
        !mosiPad.oe_n && misoPad.oe_n && shiftRxd == misoIn)
        else $error("two wire routing wrong");
    AST_HALT_FREEZES: assert property (masterSelect && !clocksRun && !(wrEn && hitRate) |=>
        st_r.preCnt == $past(st_r.preCnt) && !st_r.tick)
        else $error("divider ran while halted");
    AST_OPT_WRITE_MASKED: assert property (wrEn && hitOpt |=>
        !hitOpt || (prdata[FAULT_EN_BIT] == $past(pwdata[FAULT_EN_BIT])
        && prdata[DRIVE_EN_BIT] == $past(pwdata[DRIVE_EN_BIT])
        && prdata[HALT_WAIT_BIT] == $past(pwdata[HALT_WAIT_BIT])
        && prdata[SINGLE_WIRE_BIT] == $past(pwdata[SINGLE_WIRE_BIT])))
        else $error("option write not stored");
    // Exact period; restarts and halts are folded into the helper count
    AST_TICK_SPACING: assert property (st_r.tick |->
        $past(gapCnt) + 16'h0001 == 16'((16'(preLimit) + 16'h0001) * (RATE_BASE << st_r.rate.rateDivideField)))
        else $error("bit rate period wrong");

    AST_RATE_RESERVED_ZERO: assert property (psel && hitRate |->
        prdata[31:7] == 25'h0 && prdata[3] == 1'b0)
        else $error("reserved bit rate bits not zero");

    AST_RATE_READ_BACK: assert property (wrEn && hitRate |=>
        !hitRate || (prdata[PRESCALE_LSB +: FIELD_W] == $past(pwdata[PRESCALE_LSB +: FIELD_W])
        && prdata[RATE_LSB +: FIELD_W] == $past(pwdata[RATE_LSB +: FIELD_W])))
        else $error("bit rate write not stored");

    AST_RATE_RESTART: assert property (wrEn && hitRate |=>
        st_r.preCnt == '0 && st_r.rateCnt == '0 && !st_r.tick)
        else $error("chain not restarted by rate write");

    AST_SLAVE_CHAIN_IDLE: assert property (!masterSelect |=>
        st_r.preCnt == '0 && st_r.rateCnt == '0 && !st_r.tick)
        else $error("bit clock ran in slave mode");

    AST_PRESCALE_STEP: assert property (
        masterSelect && clocksRun && !(wrEn && hitRate) && st_r.preCnt != preLimit |=>
        st_r.preCnt == $past(st_r.preCnt) + 3'h1 && st_r.rateCnt == $past(st_r.rateCnt))
        else $error("prescaler step wrong");

    AST_RATE_STEP: assert property (
        masterSelect && clocksRun && !(wrEn && hitRate)
        && st_r.preCnt == preLimit && st_r.rateCnt != rateLimit |=>
        st_r.preCnt == '0 && st_r.rateCnt == $past(st_r.rateCnt) + 8'h01 && !st_r.tick)
        else $error("rate divider step wrong");

    AST_TICK_AT_WRAP: assert property (
        masterSelect && clocksRun && !(wrEn && hitRate)
        && st_r.preCnt == preLimit && st_r.rateCnt == rateLimit |=>
        st_r.tick && st_r.preCnt == '0 && st_r.rateCnt == '0)
        else $error("no bit clock tick at wrap");

    AST_TICK_SINGLE: assert property (st_r.tick |=> !st_r.tick)
        else $error("bit clock tick longer than a cycle");

    AST_SINGLE_WIRE_SLAVE: assert property (st_r.opt.singleWireSelect && !masterSelect |->
        misoPad.oe_n == !st_r.opt.singleWireDriveEnable && mosiGpio && mosiPad.oe_n && shiftRxd == misoIn)
        else $error("single wire slave pin wrong");

    AST_TWO_WIRE_SLAVE: assert property (!st_r.opt.singleWireSelect && !masterSelect |->
        !misoPad.oe_n && mosiPad.oe_n && shiftRxd == mosiIn)
        else $error("two wire slave routing wrong");

    AST_DRIVE_ENABLE_IGNORED: assert property (!st_r.opt.singleWireSelect |->
        !mosiGpio && !misoGpio && mosiPad.oe_n != misoPad.oe_n)
        else $error("two wire pins depend on drive enable");
endmodule
`default_nettype wire

// ---- tb/spi_far_device.sv ----
// Far-side serial device model on the shared pins
`timescale 1ns/1ns
`default_nettype none
module spi_far_device
    import spi_cfg_pkg::*;
(
    input wire logic clock,
    input wire pad_t mosiPad,
    input wire pad_t misoPad,
    input wire pad_t selectPad,
    input wire logic selectDrive,
    output logic mosiIn,
    output logic misoIn,
    output logic selectIn
);
    logic wiggle_r = 1'b0;
    // Released data lines keep changing, so a stale level never passes
    always @(posedge clock)
        wiggle_r <= ~wiggle_r;
    assign mosiIn = mosiPad.oe_n ? wiggle_r : mosiPad.out;
    assign misoIn = misoPad.oe_n ? ~wiggle_r : misoPad.out;
    assign selectIn = selectPad.oe_n ? selectDrive : selectPad.out;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the option and bit-rate block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import spi_cfg_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, m, sw, de, fe, soe, hw;
    logic masterSelect = 1'b0, selectOutputEnable = 1'b0, waitMode = 1'b0;
    logic shiftTxd = 1'b0, shiftSelectLevel = 1'b1, selectDrive = 1'b1;
    logic mosiIn, misoIn, selectIn, shiftRxd, slaveSelect_n, faultSense_n;
    logic mosiGpio, misoGpio, selectGpio, clocksRun, bitRateTick;
    pad_t mosiPad, misoPad, selectPad;
    int errors = 0, tests_run = 0, cyc = 0, k;
    always #50 clock = ~clock;
    spi_pin_mode_and_baud_config uut (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .masterSelect, .selectOutputEnable, .waitMode, .shiftTxd,
        .shiftRxd, .shiftSelectLevel, .mosiIn, .mosiPad, .misoIn, .misoPad, .selectIn, .selectPad,
        .slaveSelect_n, .faultSense_n, .mosiGpio, .misoGpio, .selectGpio, .clocksRun, .bitRateTick);
    spi_far_device far (.clock, .mosiPad, .misoPad, .selectPad, .selectDrive, .mosiIn, .misoIn, .selectIn);
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never completes
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waittick;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (bitRateTick !== 1'b1 && k < 3000);
    endtask
    task automatic period(input int p, input int r);
        apb(1'b1, BIT_RATE_SELECT_ADDR, 32'((p << 4) | r));
        waittick();
        waittick();
        check(33'(k), 33'((p + 1) << (r + 1)));
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        apb(1'b0, OPTION_CONTROL_ADDR, '0);
        check({err, rd}, 33'h0);
        apb(1'b1, OPTION_CONTROL_ADDR, 32'hffffffff);
        apb(1'b0, OPTION_CONTROL_ADDR, '0);
        check({err, rd}, 33'h1b);
        apb(1'b1, BIT_RATE_SELECT_ADDR, 32'hff);
        apb(1'b0, BIT_RATE_SELECT_ADDR, '0);
        check({err, rd}, 33'h77);
        apb(1'b0, 12'h008, '0);
        check({err, rd}, 33'h100000000);
        $display("registers test done");
        for (int i = 0; i < 64; i++)
        begin
            {hw, soe, m, sw, de, fe} = 6'(i);
            apb(1'b1, OPTION_CONTROL_ADDR, {27'h0, fe, de, 1'b0, hw, sw});
            masterSelect <= m;
            selectOutputEnable <= soe;
            waitMode <= i[2];
            selectDrive <= i[1];
            // Data levels differ from the far side's idle level in some steps
            shiftTxd <= hw;
            shiftSelectLevel <= !hw;
            @(posedge clock);
            #1;
            check(33'({mosiPad.oe_n, misoPad.oe_n, mosiGpio, misoGpio}), 33'({m ? sw & !de : 1'b1,
                m ? 1'b1 : sw & !de, sw & !m, sw & m}));
            check(33'(shiftRxd), 33'((sw & de) ? hw : far.wiggle_r ^ (m ^ sw)));
            check(33'(m ? mosiIn : misoIn), 33'((!sw | de) ? hw : far.wiggle_r ^ !m));
            check(33'({selectPad.oe_n, selectGpio, slaveSelect_n, faultSense_n, selectIn}),
                33'({!(m & fe & soe), m & !fe, m | i[1], !(m & fe & !soe) | i[1],
                ((m & fe & soe) ? !hw : i[1])}));
            check(33'(clocksRun), 33'(!(i[2] & hw)));
        end
        $display("pins test done");
        apb(1'b1, BIT_RATE_SELECT_ADDR, '0);
        masterSelect <= 1'b0;
        waitMode <= 1'b0;
        waittick();
        check(33'(k), 33'(3000));
        masterSelect <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            period(i, 7 - i);
            period(i, i);
        end
        $display("bit rate test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
